/* File: src/hmsc_params.svh */
`ifndef HMSC_PARAMS_SVH
`define HMSC_PARAMS_SVH

// Register byte addresses
`define HMSC_ADDR_WCOUNT 32'h0300_0FF0
`define HMSC_ADDR_MEMCTL 32'h0300_0FF4
`define HMSC_ADDR_VERSION 32'h0300_0FF8
`define HMSC_ADDR_MAINCTL 32'h0300_0FFC
// Buffer window: 512 words from the base
`define HMSC_BUF_BASE 32'h0300_0000
`define HMSC_BUF_WIN_LSB 11
`define HMSC_BUF_IDX_LSB 2
`define HMSC_BUF_IDX_MSB 10

// Main control fields
`define HMSC_MC_RESET 31
`define HMSC_MC_LOAD 0
`define HMSC_MC_UNLOAD 1
`define HMSC_MC_STREAM 2
`define HMSC_MC_RESET_VAL 32'h8000_0000
// Memory block control fields
`define HMSC_MB_LOAD_DONE 0
`define HMSC_MB_UNLOAD 1

// Sizes
`define HMSC_BUF_AW 9
`define HMSC_BUF_WORDS 10'h200
`define HMSC_LAST_WORD 9'h1FF
`define HMSC_STORE_AW 15
`define HMSC_BLK_AW 6
`define HMSC_DW 32
// Router sequencer spacing
`define HMSC_GAP_LAST 3'h6
`define HMSC_BURST_LAST 3'h7

`endif

/* File: src/hmsc_pkg.sv */
package hmsc_pkg;
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_LOAD,
        MODE_UNLOAD,
        MODE_STREAM
    } hmsc_mode_t;

    typedef enum logic [3:0] {
        SEQ_INIT,
        SEQ_START,
        SEQ_RELEASE,
        SEQ_SYNC1,
        SEQ_GAP1,
        SEQ_SYNC2,
        SEQ_GAP2,
        SEQ_PREFETCH,
        SEQ_DATA,
        SEQ_END
    } hmsc_seq_t;
endpackage : hmsc_pkg

/* File: src/hmsc_word_mem.sv */
`timescale 1ns/1ps
module hmsc_word_mem #(
    parameter int AW = 9,
    parameter int DW = 32
) (
    input wire logic clk_sys,
    input wire logic ce,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData_r
);
    logic [DW-1:0] mem [0:(2**AW)-1];

    // Storage has no reset; one-cycle read
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            if (rdEn) begin
                rdData_r <= mem[rdAddr];
            end
        end
    end
endmodule : hmsc_word_mem

/* File: src/hmsc_stream_seq.sv */
`timescale 1ns/1ps
`include "hmsc_params.svh"
module hmsc_stream_seq (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic streamOn,
    output logic releaseIb_r,
    output logic frameSync_r,
    output logic dataValid_r,
    output logic memEn_r
);
    hmsc_pkg::hmsc_seq_t state_r, state_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic releaseIb_nxt, frameSync_nxt, dataValid_nxt, memEn_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            hmsc_pkg::SEQ_INIT: if (streamOn) state_nxt = hmsc_pkg::SEQ_START;
            hmsc_pkg::SEQ_START: state_nxt = hmsc_pkg::SEQ_RELEASE;
            hmsc_pkg::SEQ_RELEASE: state_nxt = hmsc_pkg::SEQ_SYNC1;
            hmsc_pkg::SEQ_SYNC1: begin
                state_nxt = hmsc_pkg::SEQ_GAP1;
                cnt_nxt = 3'h0;
            end
            hmsc_pkg::SEQ_GAP1: begin
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == `HMSC_GAP_LAST) state_nxt = hmsc_pkg::SEQ_SYNC2; // R17
            end
            hmsc_pkg::SEQ_SYNC2: begin
                state_nxt = hmsc_pkg::SEQ_GAP2;
                cnt_nxt = 3'h0;
            end
            hmsc_pkg::SEQ_GAP2: begin
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == `HMSC_GAP_LAST) state_nxt = hmsc_pkg::SEQ_PREFETCH; // R17
            end
            hmsc_pkg::SEQ_PREFETCH: begin
                state_nxt = hmsc_pkg::SEQ_DATA;
                cnt_nxt = 3'h0;
            end
            hmsc_pkg::SEQ_DATA: begin
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == `HMSC_BURST_LAST && !streamOn) begin
                    state_nxt = hmsc_pkg::SEQ_END; // R15
                end
            end
            hmsc_pkg::SEQ_END: state_nxt = hmsc_pkg::SEQ_INIT;
            default: state_nxt = hmsc_pkg::SEQ_INIT;
        endcase
    end

    // Outputs follow the next state so they leave flops
    always_comb begin
        releaseIb_nxt = (state_nxt == hmsc_pkg::SEQ_RELEASE) ||
                        (state_nxt == hmsc_pkg::SEQ_SYNC1);
        frameSync_nxt = (state_nxt == hmsc_pkg::SEQ_SYNC1) ||
                        (state_nxt == hmsc_pkg::SEQ_SYNC2) ||
                        (state_nxt == hmsc_pkg::SEQ_DATA && cnt_nxt == 3'h0); // R17
        dataValid_nxt = (state_nxt == hmsc_pkg::SEQ_DATA); // R14
        memEn_nxt = (state_nxt == hmsc_pkg::SEQ_DATA) ||
                    (state_nxt == hmsc_pkg::SEQ_PREFETCH);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= hmsc_pkg::SEQ_INIT;
            cnt_r <= 3'h0;
            releaseIb_r <= 1'b0;
            frameSync_r <= 1'b0;
            dataValid_r <= 1'b0;
            memEn_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            releaseIb_r <= releaseIb_nxt;
            frameSync_r <= frameSync_nxt;
            dataValid_r <= dataValid_nxt;
            memEn_r <= memEn_nxt;
        end
    end
endmodule : hmsc_stream_seq

/* File: src/hmsc_top.sv */
`timescale 1ns/1ps
`include "hmsc_params.svh"
// Operation
// R01: Device held in reset until host clears bit
// R02: Host writes reset bit then zero
// R03: Accesses act only after reset release; main control writes also act while in reset
// R04: Read-only image version register
// R05: Writing load bit enters loading sequence
// R06: Host writes 512 words per block
// R07: Load-done bit copies buffer into storage
// R08: Word count register reports moved words
// R09: Clearing load bit ends loading
// R10: Setting unload bit enters unloading sequence
// R11: Block-unload bit copies storage block to buffer
// R12: Host reads 512 words per unloaded block
// R13: Clearing unload bit ends unloading
// R14: Stream bit starts router output streaming
// R15: Clearing control stops streaming, ready again
// R16: Optional input registering adds one stage
// R17: Frame syncs eight cycles apart at setup
// R18: All registers are single 32-bit words
module hmsc_top #(
    parameter bit REG_INPUTS = 1'b0,
    parameter logic [31:0] IMAGE_VERSION = 32'h0000_0101 // Arbitrary value
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic hostReq,
    input wire logic hostWr,
    input wire logic [31:0] hostAddr,
    input wire logic [31:0] hostWrData,
    output logic hostAck_r,
    output logic [31:0] hostRdData_r,
    output logic routerReleaseIb_r,
    output logic routerFrameSync_r,
    output logic routerDataValid_r,
    output logic [31:0] routerData_r
);
    // ------------------------------------------------------------
    // Host input stage
    // ------------------------------------------------------------
    logic aReq, aWr;
    logic [31:0] aAddr, aData;

    generate
        if (REG_INPUTS) begin : g_inreg
            logic req_r, wr_r;
            logic [31:0] addr_r, data_r;
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    req_r <= 1'b0;
                    wr_r <= 1'b0;
                    addr_r <= 32'h0000_0000;
                    data_r <= 32'h0000_0000;
                end else if (ce) begin
                    req_r <= hostReq; // R16
                    wr_r <= hostWr;
                    addr_r <= hostAddr;
                    data_r <= hostWrData;
                end
            end
            assign aReq = req_r;
            assign aWr = wr_r;
            assign aAddr = addr_r;
            assign aData = data_r;
        end else begin : g_indirect
            assign aReq = hostReq;
            assign aWr = hostWr;
            assign aAddr = hostAddr;
            assign aData = hostWrData;
        end
    endgenerate

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [31:0] mainCtl_r, mainCtl_nxt;
    logic [1:0] memCtl_r, memCtl_nxt;
    logic [31:0] wordCount_r, wordCount_nxt;
    logic inReset, copyBusy;
    logic selMain, selMem, selCount, selVer, selBuf;
    logic [`HMSC_BUF_AW-1:0] hostIdx;

    assign inReset = mainCtl_r[`HMSC_MC_RESET];
    assign selMain = (aAddr == `HMSC_ADDR_MAINCTL);
    assign selMem = (aAddr == `HMSC_ADDR_MEMCTL);
    assign selCount = (aAddr == `HMSC_ADDR_WCOUNT);
    assign selVer = (aAddr == `HMSC_ADDR_VERSION);
    assign selBuf = ((aAddr >> `HMSC_BUF_WIN_LSB) == (`HMSC_BUF_BASE >> `HMSC_BUF_WIN_LSB));
    assign hostIdx = aAddr[`HMSC_BUF_IDX_MSB:`HMSC_BUF_IDX_LSB];

    logic hostBufWr, hostBufRd, wrMain, wrMem;
    assign hostBufWr = aReq && aWr && selBuf && !inReset && !copyBusy; // R03
    assign hostBufRd = aReq && !aWr && selBuf && !inReset && !copyBusy; // R03
    assign wrMain = aReq && aWr && selMain; // R02
    assign wrMem = aReq && aWr && selMem && !inReset; // R03

    // ------------------------------------------------------------
    // Main control state machine
    // ------------------------------------------------------------
    hmsc_pkg::hmsc_mode_t mode_r, mode_nxt;
    logic [`HMSC_BLK_AW-1:0] blk_r, blk_nxt;
    logic copyDone;

    always_comb begin
        mode_nxt = mode_r;
        if (inReset) begin
            mode_nxt = hmsc_pkg::MODE_IDLE; // R01
        end else begin
            case (mode_r)
                hmsc_pkg::MODE_IDLE: begin
                    if (mainCtl_r[`HMSC_MC_LOAD]) mode_nxt = hmsc_pkg::MODE_LOAD; // R05
                    else if (mainCtl_r[`HMSC_MC_UNLOAD]) mode_nxt = hmsc_pkg::MODE_UNLOAD; // R10
                    else if (mainCtl_r[`HMSC_MC_STREAM]) mode_nxt = hmsc_pkg::MODE_STREAM; // R14
                end
                hmsc_pkg::MODE_LOAD:
                    if (!mainCtl_r[`HMSC_MC_LOAD] && !copyBusy) mode_nxt = hmsc_pkg::MODE_IDLE; // R09
                hmsc_pkg::MODE_UNLOAD:
                    if (!mainCtl_r[`HMSC_MC_UNLOAD] && !copyBusy) mode_nxt = hmsc_pkg::MODE_IDLE; // R13
                hmsc_pkg::MODE_STREAM:
                    if (!mainCtl_r[`HMSC_MC_STREAM]) mode_nxt = hmsc_pkg::MODE_IDLE; // R15
                default: mode_nxt = hmsc_pkg::MODE_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Copy engine between buffer and storage
    // ------------------------------------------------------------
    logic copyUnload_r, copyUnload_nxt, copyBusy_r, copyBusy_nxt;
    logic [`HMSC_BUF_AW:0] rdIdx_r, rdIdx_nxt;
    logic [`HMSC_BUF_AW-1:0] wrIdx_r, wrIdx_nxt;
    logic wrPend_r, wrPend_nxt;
    logic startLoad, startUnload, copyRd;

    assign copyBusy = copyBusy_r;
    assign startLoad = wrMem && aData[`HMSC_MB_LOAD_DONE] && !copyBusy_r &&
                       mode_r == hmsc_pkg::MODE_LOAD; // R07
    assign startUnload = wrMem && aData[`HMSC_MB_UNLOAD] && !copyBusy_r &&
                         mode_r == hmsc_pkg::MODE_UNLOAD; // R11
    assign copyRd = copyBusy_r && rdIdx_r != `HMSC_BUF_WORDS;
    assign copyDone = copyBusy_r && rdIdx_r == `HMSC_BUF_WORDS && !wrPend_r;

    always_comb begin
        copyBusy_nxt = copyBusy_r;
        copyUnload_nxt = copyUnload_r;
        rdIdx_nxt = rdIdx_r;
        wrIdx_nxt = wrIdx_r;
        wrPend_nxt = copyRd;
        blk_nxt = blk_r;
        wordCount_nxt = wordCount_r;
        if (mode_r == hmsc_pkg::MODE_IDLE && mode_nxt != hmsc_pkg::MODE_IDLE) begin
            blk_nxt = '0;
        end
        if (startLoad || startUnload) begin
            copyBusy_nxt = 1'b1;
            copyUnload_nxt = startUnload;
            rdIdx_nxt = '0;
            wordCount_nxt = 32'h0000_0000;
        end else if (copyRd) begin
            rdIdx_nxt = rdIdx_r + 1'b1;
            wrIdx_nxt = rdIdx_r[`HMSC_BUF_AW-1:0];
        end
        if (wrPend_r) begin
            wordCount_nxt = wordCount_r + 32'h0000_0001; // R08
        end
        if (copyDone) begin
            copyBusy_nxt = 1'b0;
            blk_nxt = blk_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------
    logic [31:0] bufRdData, storeRdData;
    logic bufWe, storeWe, storeRe, seqMemEn;
    logic [`HMSC_BUF_AW-1:0] bufWrAddr, bufRdAddr;
    logic [`HMSC_STORE_AW-1:0] storeRdAddr, streamPtr_r, streamPtr_nxt;

    assign bufWe = hostBufWr || (wrPend_r && copyUnload_r);
    assign bufWrAddr = copyBusy_r ? wrIdx_r : hostIdx;
    assign bufRdAddr = copyBusy_r ? rdIdx_r[`HMSC_BUF_AW-1:0] : hostIdx;
    assign storeWe = wrPend_r && !copyUnload_r;
    assign storeRe = (copyRd && copyUnload_r) || seqMemEn;
    assign storeRdAddr = copyBusy_r ? {blk_r, rdIdx_r[`HMSC_BUF_AW-1:0]} : streamPtr_r;
    assign streamPtr_nxt = seqMemEn ? streamPtr_r + 1'b1 :
                           (mode_r == hmsc_pkg::MODE_STREAM ? streamPtr_r : '0);

    hmsc_word_mem #(.AW(`HMSC_BUF_AW), .DW(`HMSC_DW)) u_buffer (
        .clk_sys(clk_sys),
        .ce(ce),
        .wrEn(bufWe),
        .wrAddr(bufWrAddr),
        .wrData(copyBusy_r ? storeRdData : aData),
        .rdEn(1'b1),
        .rdAddr(bufRdAddr),
        .rdData_r(bufRdData)
    );

    hmsc_word_mem #(.AW(`HMSC_STORE_AW), .DW(`HMSC_DW)) u_storage (
        .clk_sys(clk_sys),
        .ce(ce),
        .wrEn(storeWe),
        .wrAddr({blk_r, wrIdx_r}),
        .wrData(bufRdData),
        .rdEn(storeRe),
        .rdAddr(storeRdAddr),
        .rdData_r(storeRdData)
    );

    // ------------------------------------------------------------
    // Router output sequencer
    // ------------------------------------------------------------
    logic seqRelease, seqSync, seqValid;

    hmsc_stream_seq u_seq (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .streamOn(mode_r == hmsc_pkg::MODE_STREAM), // R14
        .releaseIb_r(seqRelease),
        .frameSync_r(seqSync),
        .dataValid_r(seqValid),
        .memEn_r(seqMemEn)
    );

    // ------------------------------------------------------------
    // Register writes and host answer
    // ------------------------------------------------------------
    logic rdPend_r, rdPend_nxt, rdBuf_r, rdBuf_nxt, ackPend_r, ackPend_nxt;
    logic [31:0] rdReg_r, rdReg_nxt, hostRdData_nxt;
    logic hostAck_nxt;

    always_comb begin
        mainCtl_nxt = mainCtl_r;
        memCtl_nxt = memCtl_r;
        if (wrMain) mainCtl_nxt = aData; // R01
        if (startLoad || startUnload) begin
            memCtl_nxt = aData[`HMSC_MB_UNLOAD:`HMSC_MB_LOAD_DONE];
        end
        if (copyDone) memCtl_nxt = 2'h0;
        ackPend_nxt = aReq;
        rdPend_nxt = aReq && !aWr;
        rdBuf_nxt = hostBufRd;
        rdReg_nxt = 32'h0000_0000;
        if (aReq && !aWr && !inReset) begin // R03
            if (selMain) rdReg_nxt = mainCtl_r; // R18
            else if (selMem) rdReg_nxt = {30'h0000_0000, memCtl_r};
            else if (selCount) rdReg_nxt = wordCount_r; // R08
            else if (selVer) rdReg_nxt = IMAGE_VERSION; // R04
        end
        hostAck_nxt = ackPend_r;
        hostRdData_nxt = rdBuf_r ? bufRdData : rdReg_r;
        if (!rdPend_r) hostRdData_nxt = 32'h0000_0000;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mainCtl_r <= `HMSC_MC_RESET_VAL; // R01
            memCtl_r <= 2'h0;
            mode_r <= hmsc_pkg::MODE_IDLE;
            blk_r <= '0;
            copyBusy_r <= 1'b0;
            copyUnload_r <= 1'b0;
            rdIdx_r <= '0;
            wrIdx_r <= '0;
            wrPend_r <= 1'b0;
            wordCount_r <= 32'h0000_0000;
            streamPtr_r <= '0;
            ackPend_r <= 1'b0;
            rdPend_r <= 1'b0;
            rdBuf_r <= 1'b0;
            rdReg_r <= 32'h0000_0000;
            hostAck_r <= 1'b0;
            hostRdData_r <= 32'h0000_0000;
            routerReleaseIb_r <= 1'b0;
            routerFrameSync_r <= 1'b0;
            routerDataValid_r <= 1'b0;
            routerData_r <= 32'h0000_0000;
        end else if (ce) begin
            mainCtl_r <= mainCtl_nxt;
            memCtl_r <= memCtl_nxt;
            mode_r <= mode_nxt;
            blk_r <= blk_nxt;
            copyBusy_r <= copyBusy_nxt;
            copyUnload_r <= copyUnload_nxt;
            rdIdx_r <= rdIdx_nxt;
            wrIdx_r <= wrIdx_nxt;
            wrPend_r <= wrPend_nxt;
            wordCount_r <= wordCount_nxt;
            streamPtr_r <= streamPtr_nxt;
            ackPend_r <= ackPend_nxt;
            rdPend_r <= rdPend_nxt;
            rdBuf_r <= rdBuf_nxt;
            rdReg_r <= rdReg_nxt;
            hostAck_r <= hostAck_nxt;
            hostRdData_r <= hostRdData_nxt;
            // Delay of one aligns strobes with storage read data
            routerReleaseIb_r <= seqRelease;
            routerFrameSync_r <= seqSync;
            routerDataValid_r <= seqValid; // R15
            routerData_r <= seqValid ? storeRdData : 32'h0000_0000;
        end
    end
endmodule : hmsc_top

/* File: verification/hmsc_chk.sv */
`timescale 1ns/1ps
`include "hmsc_params.svh"
module hmsc_chk #(
    parameter bit REG_INPUTS = 1'b0,
    parameter logic [31:0] IMAGE_VERSION = 32'h0000_0101 // Arbitrary value
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic hostReq,
    input wire logic hostWr,
    input wire logic [31:0] hostAddr,
    input wire logic [31:0] hostWrData,
    input wire logic hostAck_r,
    input wire logic [31:0] hostRdData_r,
    input wire logic routerReleaseIb_r,
    input wire logic routerFrameSync_r,
    input wire logic routerDataValid_r,
    input wire logic [31:0] routerData_r
);
    localparam int L = REG_INPUTS ? 2 : 1;
    logic take, mcWr, rstBit_r, rstBit_nxt;
    logic [2:0] reqP_r, reqP_nxt, wrP_r, wrP_nxt, verP_r, verP_nxt, refP_r, refP_nxt;
    // --------
    // Shadow of host requests
    // --------
    always_comb begin
        take = ce && hostReq;
        mcWr = take && hostWr && hostAddr == `HMSC_ADDR_MAINCTL;
        rstBit_nxt = mcWr ? hostWrData[`HMSC_MC_RESET] : rstBit_r;
        reqP_nxt = {reqP_r[1:0], take};
        wrP_nxt = {wrP_r[1:0], take && hostWr};
        verP_nxt = {verP_r[1:0], take && !hostWr && !rstBit_r && hostAddr == `HMSC_ADDR_VERSION};
        refP_nxt = {refP_r[1:0], take && rstBit_r && !mcWr};
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {rstBit_r, reqP_r, wrP_r, verP_r, refP_r} <= {1'b1, 12'h000};
        end else if (ce) begin
            {rstBit_r, reqP_r, wrP_r, verP_r, refP_r} <=
                {rstBit_nxt, reqP_nxt, wrP_nxt, verP_nxt, refP_nxt};
        end
    end
    // --------
    // Properties
    // --------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_ack; hostAck_r == reqP_r[L]; endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    property p_wrz; hostAck_r && wrP_r[L] |-> hostRdData_r == 32'h0; endproperty
    a_wrz: assert property (p_wrz) else $error("write ack data");
    property p_idz; !hostAck_r |-> hostRdData_r == 32'h0; endproperty
    a_idz: assert property (p_idz) else $error("read data outside ack");
    property p_ver; verP_r[L] |-> hostRdData_r == IMAGE_VERSION; endproperty
    a_ver: assert property (p_ver) else $error("version value");
    property p_ref; refP_r[L] |-> hostRdData_r == 32'h0; endproperty
    a_ref: assert property (p_ref) else $error("access acted in reset");
    property p_gap; routerFrameSync_r |=> !routerFrameSync_r [*7]; endproperty
    a_gap: assert property (p_gap) else $error("sync too soon");
    property p_nxt;
        routerFrameSync_r && routerReleaseIb_r |-> ##8 routerFrameSync_r && !routerDataValid_r
            ##9 routerFrameSync_r && routerDataValid_r;
    endproperty
    a_nxt: assert property (p_nxt) else $error("setup sync missing");
    property p_bst; routerFrameSync_r && routerDataValid_r |-> routerDataValid_r [*8];
    endproperty
    a_bst: assert property (p_bst) else $error("burst short");
    property p_rel;
        $rose(routerReleaseIb_r) |=> routerReleaseIb_r && routerFrameSync_r ##1 !routerReleaseIb_r;
    endproperty
    a_rel: assert property (p_rel) else $error("release timing");
    property p_vsy; $rose(routerDataValid_r) |-> routerFrameSync_r; endproperty
    a_vsy: assert property (p_vsy) else $error("burst without sync");
    property p_dz; !routerDataValid_r |-> routerData_r == 32'h0; endproperty
    a_dz: assert property (p_dz) else $error("stream data when idle");
    c_str: cover property ($rose(routerDataValid_r));
    c_end: cover property ($fell(routerDataValid_r));
    c_ver: cover property (verP_r[L] && hostAck_r);
    c_ref: cover property (refP_r[L]);
endmodule : hmsc_chk
bind hmsc_top hmsc_chk #(.REG_INPUTS(REG_INPUTS), .IMAGE_VERSION(IMAGE_VERSION)) u_hmsc_chk (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .hostReq(hostReq), .hostWr(hostWr),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostAck_r(hostAck_r),
    .hostRdData_r(hostRdData_r), .routerReleaseIb_r(routerReleaseIb_r),
    .routerFrameSync_r(routerFrameSync_r), .routerDataValid_r(routerDataValid_r),
    .routerData_r(routerData_r)
);

/* File: verification/hmsc_host.sv */
`timescale 1ns/1ps
module hmsc_host (
    input wire logic clk_sys,
    input wire logic hostAck_r,
    output logic hostReq,
    output logic hostWr,
    output logic [31:0] hostAddr,
    output logic [31:0] hostWrData
);
    initial begin
        hostReq = 1'b0;
        hostWr = 1'b0;
        hostAddr = 32'h0;
        hostWrData = 32'h0;
    end
    // --------
    // One word access, random idle gap first
    // --------
    task automatic access(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        repeat ($urandom % 3) @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        hostReq = 1'b1;
        hostWr = w;
        hostAddr = a;
        hostWrData = d;
        @(posedge clk_sys);
        #1;
        // Released lines show garbage, not the old value
        hostReq = 1'b0;
        hostWr = ~w;
        hostAddr = ~a;
        hostWrData = ~d;
        while (hostAck_r !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask : access
endmodule : hmsc_host

/* File: verification/hmsc_top_tb.sv */
`timescale 1ns/1ps
`include "hmsc_params.svh"
module hmsc_top_tb;
    localparam logic [31:0] VER = 32'h0000_0A5C; // Arbitrary value
    localparam logic [31:0] MC = `HMSC_ADDR_MAINCTL;
    localparam logic [31:0] MB = `HMSC_ADDR_MEMCTL;
    localparam logic [31:0] WC = `HMSC_ADDR_WCOUNT;
    localparam logic [31:0] VA = `HMSC_ADDR_VERSION;
    localparam logic [31:0] BB = `HMSC_BUF_BASE;
    logic clk_sys, resetn, ce, hostReq, hostWr, hostAck_r;
    logic routerReleaseIb_r, routerFrameSync_r, routerDataValid_r;
    logic [31:0] hostAddr, hostWrData, hostRdData_r, routerData_r;
    logic [31:0] expQ[$], strQ[$], img[$];
    int miscompares, checks, cyc, nWords;
    hmsc_top #(.REG_INPUTS(1'b0), .IMAGE_VERSION(VER)) u_hmsc_top (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .hostReq(hostReq), .hostWr(hostWr),
        .hostAddr(hostAddr), .hostWrData(hostWrData), .hostAck_r(hostAck_r),
        .hostRdData_r(hostRdData_r), .routerReleaseIb_r(routerReleaseIb_r),
        .routerFrameSync_r(routerFrameSync_r), .routerDataValid_r(routerDataValid_r),
        .routerData_r(routerData_r)
    );
    hmsc_host u_hmsc_host (
        .clk_sys(clk_sys), .hostAck_r(hostAck_r), .hostReq(hostReq), .hostWr(hostWr),
        .hostAddr(hostAddr), .hostWrData(hostWrData)
    );
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude;
        $display("miscompares %0d checks %0d", miscompares, checks);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    task automatic acc(input logic w, input logic [31:0] a, d, e);
        expQ.push_back(e);
        u_hmsc_host.access(w, a, d);
    endtask : acc
    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : waitCyc
    // --------
    // Output watcher and timeout
    // --------
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 40000) begin
            miscompares++;
            conclude();
        end
        if (hostAck_r === 1'b1) begin
            chk(32'(expQ.size() > 0), 32'h1);
            if (expQ.size() > 0) chk(hostRdData_r, expQ.pop_front());
        end
        if (routerDataValid_r === 1'b1) begin
            nWords++;
            if (strQ.size() > 0) chk(routerData_r, strQ.pop_front());
        end
    end
    // --------
    // Main sequence
    // --------
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        miscompares = 0;
        checks = 0;
        cyc = 0;
        nWords = 0;
        void'($urandom(32'hC978));
        waitCyc(5);
        resetn = 1'b1;
        acc(1'b0, VA, 32'h0, 32'h0);
        acc(1'b0, MC, 32'h0, 32'h0);
        acc(1'b1, MB, 32'h1, 32'h0);
        acc(1'b1, MC, 32'h8000_0000, 32'h0);
        acc(1'b1, MC, 32'h0, 32'h0);
        acc(1'b0, MB, 32'h0, 32'h0);
        acc(1'b0, VA, 32'h0, VER);
        acc(1'b1, VA, 32'hFFFF_FFFF, 32'h0);
        acc(1'b0, VA, 32'h0, VER);
        acc(1'b0, 32'h0300_0F00, 32'h0, 32'h0);
        acc(1'b1, MC, 32'h1, 32'h0);
        acc(1'b0, MC, 32'h0, 32'h1);
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 512; i++) begin
                img.push_back($urandom);
                acc(1'b1, BB + 32'(4 * i), img[$], 32'h0);
            end
            acc(1'b1, MB, 32'h1, 32'h0);
            acc(1'b0, MB, 32'h0, 32'h1);
            waitCyc(600);
            acc(1'b0, MB, 32'h0, 32'h0);
            acc(1'b0, WC, 32'h0, 32'h200);
        end
        acc(1'b1, MC, 32'h0, 32'h0);
        acc(1'b0, MC, 32'h0, 32'h0);
        acc(1'b1, MC, 32'h2, 32'h0);
        for (int b = 0; b < 2; b++) begin
            acc(1'b1, MB, 32'h2, 32'h0);
            acc(1'b0, MB, 32'h0, 32'h2);
            waitCyc(600);
            acc(1'b0, WC, 32'h0, 32'h200);
            for (int i = 0; i < 512; i++) begin
                acc(1'b0, BB + 32'(4 * i), 32'h0, img[512 * b + i]);
            end
        end
        acc(1'b1, MC, 32'h0, 32'h0);
        acc(1'b0, MC, 32'h0, 32'h0);
        // Two stream runs: the second must restart at word zero
        for (int r = 0; r < 2; r++) begin
            strQ = img;
            nWords = 0;
            acc(1'b1, MC, 32'h4, 32'h0);
            waitCyc(40 + $urandom % 40);
            acc(1'b1, MC, 32'h0, 32'h0);
            waitCyc(20);
            chk(32'(nWords % 8), 32'h0);
            chk(32'(nWords >= 8), 32'h1);
            chk({31'h0, routerReleaseIb_r | routerDataValid_r}, 32'h0);
        end
        chk(32'(expQ.size()), 32'h0);
        conclude();
    end
endmodule : hmsc_top_tb
